// ==== core/lbst_tracker.sv ====
// top of the bank state tracker: cke and power modes, command gating, one machine per bank
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - leaving resetting power-down goes idle if tINIT5 expired, else stays resetting
// - bank commands count only with cke high on previous and current edge
// - activate on idle bank opens row, activating until tRCD, then active
// - per-bank refresh only on idle bank, refreshing until tRFCpb, then idle
// - all-bank refresh needs all idle, lasts tRFCab, ends all idle
// - mode write from all idle holds writing state until tMRW, then idle
// - mode read from idle, active or resetting lasts tMRR, then returns
// - reset via mode write from all idle or power-on enters resetting
// - precharge closes row, precharging until tRP, then idle; precharge-all likewise
// - precharge to an idle bank still imposes tRP
// - active bank: read starts reading, write starts writing, mode read reads
// - new read or write, with or without auto-precharge, accepted during a burst without auto-precharge
// - burst terminate ends the most recent read or write burst if it has no auto-precharge, bank goes active
// - auto-precharge burst keeps bank busy until tRP after precharge, ends idle
// - self-refresh and deep power-down exits are asynchronous, not sampled commands
// - per-bank refresh only on eight-bank devices
module lbst_tracker import lbst_pkg::*; #(
  parameter int NUM_BANKS = 8,
  parameter int BA_W = $clog2(NUM_BANKS),
  parameter int RCD_C = RCD_CYC,
  parameter int RP_C = RP_CYC,
  parameter int RFCPB_C = RFCPB_CYC,
  parameter int RFCAB_C = RFCAB_CYC,
  parameter int MRW_C = MRW_CYC,
  parameter int MRR_C = MRR_CYC,
  parameter int XP_C = XP_CYC,
  parameter int XSR_C = XSR_CYC,
  parameter int INIT5_C = INIT5_CYC,
  parameter int BURST_C = BURST_CLKS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // clock enable pin
  input wire logic ckePin,
  // decoded command from the command/address capture
  input wire lbst_cmd_e cmd,
  input wire logic [BA_W-1:0] bankAddr,
  input wire logic allBank,
  input wire logic autoPre,
  // status
  output logic [NUM_BANKS*BANK_W-1:0] bankState,
  output lbst_pwr_e powerMode_r,
  output logic illegalCmd_r,
  output logic cmdTaken_r,
  output logic nopLock_r,
  output logic initDone_r,
  output logic allIdle_r
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (NUM_BANKS != 4 && NUM_BANKS != 8) begin : gBanksChk
    $error("NUM_BANKS must be 4 or 8");
  end
  // a zero interval would leave a bank timer at rest and the bank stuck in its transient
  if (INIT5_C >= (1 << TMR_W) || XSR_C >= (1 << TMR_W) || XP_C < 1 || BURST_C < 1 || RCD_C < 1 || RP_C < 1 ||
      RFCPB_C < 1 || RFCAB_C < 1 || MRW_C < 1 || MRR_C < 1) begin : gTmrChk
    $error("timing count out of range");
  end

  logic rstSync1_r;
  logic rstSync2_r;
  logic rstN;
  logic ckeS1_r;
  logic ckeS2_r;
  logic ckeS3_r;
  logic ckeLvl_r;
  logic ckePrev_r;
  logic ckeRise;
  logic ckeFall;
  logic ckeBoth;
  logic go;
  logic commit;
  logic violation;
  logic anyBad;
  logic anyStrict;
  logic allIdle;
  logic initExit;
  logic toPowerOn;
  logic [TMR_W-1:0] exitTmr_r;
  logic [TMR_W-1:0] initTmr_r;
  logic [BA_W-1:0] lastRw_r;
  logic [NUM_BANKS-1:0] badV;
  logic [NUM_BANKS-1:0] strictV;
  logic [NUM_BANKS-1:0] idleV;

  // ****************************************************************
  // reset release and cke synchroniser
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end
  assign rstN = rstSync2_r;

  // cke exits from self-refresh and deep power-down arrive unclocked, so only a filtered level is used
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ckeS1_r <= 1'b0;
      ckeS2_r <= 1'b0;
      ckeS3_r <= 1'b0;
      ckeLvl_r <= 1'b0;
      ckePrev_r <= 1'b0;
    end else begin
      ckeS1_r <= ckePin;
      ckeS2_r <= ckeS1_r;
      ckeS3_r <= ckeS2_r;
      if (ckeS2_r == ckeS3_r) begin
        ckeLvl_r <= ckeS3_r;
      end
      ckePrev_r <= ckeLvl_r;
    end
  end

  assign ckeRise = ckeLvl_r && !ckePrev_r;
  assign ckeFall = ckePrev_r && !ckeLvl_r;
  assign ckeBoth = ckeLvl_r && ckePrev_r;

  // ****************************************************************
  // command gating
  // ****************************************************************
  assign anyBad = |badV;
  assign anyStrict = |strictV;
  assign allIdle = &idleV;
  // bank commands only with cke high on both edges, in normal mode
  assign go = ckeBoth && (powerMode_r == PW_NORMAL) && (cmd != CMD_NOP) && !nopLock_r && !anyStrict;
  // anything but NOP while locked is flagged and dropped
  assign violation = ckeBoth && (powerMode_r == PW_NORMAL) && (cmd != CMD_NOP) && (nopLock_r || anyStrict);
  // one bank refusing a device-wide command rejects it for all banks
  assign commit = go && !anyBad;
  assign initExit = (powerMode_r == PW_PDOWN) && ckeRise && initDone_r;
  assign toPowerOn = (powerMode_r == PW_DPD) && ckeRise;

  // ****************************************************************
  // bank machines
  // ****************************************************************
  for (genvar i = 0; i < NUM_BANKS; i++) begin : gBank
    lbst_bank_e bankSt;
    lbst_bank #(
      .RCD_C(RCD_C),
      .RP_C(RP_C),
      .RFCPB_C(RFCPB_C),
      .RFCAB_C(RFCAB_C),
      .MRW_C(MRW_C),
      .MRR_C(MRR_C),
      .BURST_C(BURST_C),
      .PB_REF_EN(NUM_BANKS == PB_REFRESH_BANKS)
    ) uBank (
      .clk(ref_clk),
      .rstN(rstN),
      .go(go),
      .commit(commit),
      .cmd(cmd),
      .sel(bankAddr == BA_W'(i)),
      .allBank(allBank),
      .autoPre(autoPre),
      .bstHit(lastRw_r == BA_W'(i)),
      .devIdle(allIdle),
      .initExit(initExit),
      .toPowerOn(toPowerOn),
      .state_r(bankSt),
      .bad(badV[i]),
      .strict(strictV[i]),
      .isIdle(idleV[i])
    );
    assign bankState[i*BANK_W +: BANK_W] = bankSt;
  end

  // ****************************************************************
  // power modes and exit lockout
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      powerMode_r <= PW_NORMAL;
    end else begin
      case (powerMode_r)
        PW_NORMAL: begin
          if (ckeFall) begin
            if (cmd == CMD_SREF && allIdle) begin
              powerMode_r <= PW_SREF;
            end else if (cmd == CMD_DPD && allIdle) begin
              powerMode_r <= PW_DPD;
            end else begin
              powerMode_r <= PW_PDOWN;
            end
          end
        end
        PW_PDOWN, PW_SREF, PW_DPD: begin
          if (ckeRise) begin
            powerMode_r <= PW_NORMAL;
          end
        end
        default: powerMode_r <= PW_NORMAL;
      endcase
    end
  end

  // the lockout only guards the command stream; the clock toggling it needs is the controller's duty
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      exitTmr_r <= '0;
      nopLock_r <= 1'b0;
    end else if (ckeRise && powerMode_r == PW_PDOWN) begin
      exitTmr_r <= TMR_W'(XP_C);
      nopLock_r <= 1'b1;
    end else if (ckeRise && powerMode_r == PW_SREF) begin
      exitTmr_r <= TMR_W'(XSR_C);
      nopLock_r <= 1'b1;
    end else if (exitTmr_r != '0) begin
      exitTmr_r <= exitTmr_r - TMR_ONE;
      nopLock_r <= (exitTmr_r != TMR_ONE);
    end
  end

  // ****************************************************************
  // initialisation timer and burst owner
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      initTmr_r <= '0;
      initDone_r <= 1'b0;
    end else if (commit && cmd == CMD_RESET) begin
      initTmr_r <= TMR_W'(INIT5_C);
      initDone_r <= 1'b0;
    end else if (initTmr_r != '0) begin
      initTmr_r <= initTmr_r - TMR_ONE;
      initDone_r <= (initTmr_r == TMR_ONE);
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      lastRw_r <= '0;
    end else if (commit && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
      lastRw_r <= bankAddr;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      illegalCmd_r <= 1'b0;
      cmdTaken_r <= 1'b0;
      allIdle_r <= 1'b0;
    end else begin
      illegalCmd_r <= violation || (go && anyBad);
      cmdTaken_r <= commit;
      allIdle_r <= allIdle;
    end
  end

endmodule : lbst_tracker
`default_nettype wire

// ==== core/lbst_pkg.sv ====
// shared types and timing constants for the bank state tracker
package lbst_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 10;
  localparam int NS_PER_US = 1000;
  localparam int T_RCD_NS = 18;
  localparam int T_RP_NS = 18;
  localparam int T_RFCPB_NS = 60;
  localparam int T_RFCAB_NS = 130;
  localparam int T_MRW_NS = 50;
  localparam int T_MRR_NS = 20;
  localparam int T_XP_NS = 8;
  localparam int T_XSR_NS = 140;
  localparam int T_INIT5_NS = 10000;
  localparam int BURST_CLKS = 2;

  // least times: round up, never below one cycle
  function automatic int lbst_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    return (c < 1) ? 1 : c;
  endfunction : lbst_cyc

  localparam int RCD_CYC = lbst_cyc(T_RCD_NS);
  localparam int RP_CYC = lbst_cyc(T_RP_NS);
  localparam int RFCPB_CYC = lbst_cyc(T_RFCPB_NS);
  localparam int RFCAB_CYC = lbst_cyc(T_RFCAB_NS);
  localparam int MRW_CYC = lbst_cyc(T_MRW_NS);
  localparam int MRR_CYC = lbst_cyc(T_MRR_NS);
  localparam int XP_CYC = lbst_cyc(T_XP_NS);
  localparam int XSR_CYC = lbst_cyc(T_XSR_NS);
  localparam int INIT5_CYC = lbst_cyc(T_INIT5_NS);

  localparam int TMR_W = 16;
  localparam int PB_REFRESH_BANKS = 8;
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;

  // ****************************************************************
  // bank states, commands, power modes
  // ****************************************************************
  localparam int BANK_W = 17;
  typedef enum logic [BANK_W-1:0] {
    BK_POWER_ON    = 17'h0_0001,
    BK_RESETTING   = 17'h0_0002,
    BK_IDLE        = 17'h0_0004,
    BK_ACTIVATING  = 17'h0_0008,
    BK_ACTIVE      = 17'h0_0010,
    BK_READING     = 17'h0_0020,
    BK_WRITING     = 17'h0_0040,
    BK_READ_AP     = 17'h0_0080,
    BK_WRITE_AP    = 17'h0_0100,
    BK_PRECHARGING = 17'h0_0200,
    BK_PRE_ALL     = 17'h0_0400,
    BK_REF_PB      = 17'h0_0800,
    BK_REF_AB      = 17'h0_1000,
    BK_MR_WRITING  = 17'h0_2000,
    BK_MRR_IDLE    = 17'h0_4000,
    BK_MRR_ACTIVE  = 17'h0_8000,
    BK_MRR_RESET   = 17'h1_0000
  } lbst_bank_e;

  typedef enum logic [3:0] {
    CMD_NOP   = 4'h0,
    CMD_ACT   = 4'h1,
    CMD_READ  = 4'h2,
    CMD_WRITE = 4'h3,
    CMD_PRE   = 4'h4,
    CMD_REF   = 4'h5,
    CMD_MRW   = 4'h6,
    CMD_MRR   = 4'h7,
    CMD_BST   = 4'h8,
    CMD_RESET = 4'h9,
    CMD_SREF  = 4'hA,
    CMD_DPD   = 4'hB
  } lbst_cmd_e;

  typedef enum logic [3:0] {
    PW_NORMAL = 4'h1,
    PW_PDOWN  = 4'h2,
    PW_SREF   = 4'h4,
    PW_DPD    = 4'h8
  } lbst_pwr_e;

endpackage : lbst_pkg

// ==== core/lbst_bank.sv ====
// one bank's command state machine with its own timer
`timescale 1ns/1ps
`default_nettype none
module lbst_bank import lbst_pkg::*; #(
  parameter int RCD_C = RCD_CYC,
  parameter int RP_C = RP_CYC,
  parameter int RFCPB_C = RFCPB_CYC,
  parameter int RFCAB_C = RFCAB_CYC,
  parameter int MRW_C = MRW_CYC,
  parameter int MRR_C = MRR_CYC,
  parameter int BURST_C = BURST_CLKS,
  parameter bit PB_REF_EN = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // command presented this edge
  input wire logic go,
  input wire logic commit,
  input wire lbst_cmd_e cmd,
  input wire logic sel,
  input wire logic allBank,
  input wire logic autoPre,
  input wire logic bstHit,
  input wire logic devIdle,
  // forced moves from the power logic
  input wire logic initExit,
  input wire logic toPowerOn,
  // status
  output lbst_bank_e state_r,
  output logic bad,
  output logic strict,
  output logic isIdle
);

  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] loadVal;
  lbst_bank_e cmdNxt;
  lbst_bank_e expNxt;
  logic ok;
  logic timed;
  logic hit;
  logic devWide;

  // ****************************************************************
  // legal command per state
  // ****************************************************************
  always_comb begin
    devWide = (cmd == CMD_MRW) || (cmd == CMD_MRR) || (cmd == CMD_RESET) || (cmd == CMD_SREF) ||
              (cmd == CMD_DPD) || (allBank && ((cmd == CMD_PRE) || (cmd == CMD_REF)));
    hit = devWide || ((cmd == CMD_BST) ? bstHit : sel);
    cmdNxt = state_r;
    loadVal = '0;
    ok = 1'b0;
    expNxt = state_r;
    timed = 1'b1;
    case (state_r)
      BK_POWER_ON: begin
        timed = 1'b0;
        if (cmd == CMD_RESET) begin
          ok = 1'b1;
          cmdNxt = BK_RESETTING;
        end
      end
      BK_RESETTING: begin
        timed = 1'b0;
        if (cmd == CMD_MRR) begin
          ok = 1'b1;
          cmdNxt = BK_MRR_RESET;
          loadVal = TMR_W'(MRR_C);
        end
      end
      BK_IDLE: begin
        timed = 1'b0;
        if (cmd == CMD_ACT) begin
          ok = 1'b1;
          cmdNxt = BK_ACTIVATING;
          loadVal = TMR_W'(RCD_C);
        end else if (cmd == CMD_REF && !allBank) begin
          ok = PB_REF_EN;
          cmdNxt = BK_REF_PB;
          loadVal = TMR_W'(RFCPB_C);
        end else if (cmd == CMD_REF) begin
          ok = devIdle;
          cmdNxt = BK_REF_AB;
          loadVal = TMR_W'(RFCAB_C);
        end else if (cmd == CMD_MRW) begin
          ok = devIdle;
          cmdNxt = BK_MR_WRITING;
          loadVal = TMR_W'(MRW_C);
        end else if (cmd == CMD_RESET) begin
          ok = devIdle;
          cmdNxt = BK_RESETTING;
        end else if (cmd == CMD_MRR) begin
          ok = 1'b1;
          cmdNxt = BK_MRR_IDLE;
          loadVal = TMR_W'(MRR_C);
        end else if (cmd == CMD_PRE) begin
          ok = 1'b1;
          cmdNxt = allBank ? BK_PRE_ALL : BK_PRECHARGING;
          loadVal = TMR_W'(RP_C);
        end
      end
      BK_ACTIVE: begin
        timed = 1'b0;
        if (cmd == CMD_READ || cmd == CMD_WRITE) begin
          ok = 1'b1;
          if (autoPre) begin
            cmdNxt = (cmd == CMD_READ) ? BK_READ_AP : BK_WRITE_AP;
            loadVal = TMR_W'(BURST_C + RP_C);
          end else begin
            cmdNxt = (cmd == CMD_READ) ? BK_READING : BK_WRITING;
            loadVal = TMR_W'(BURST_C);
          end
        end else if (cmd == CMD_MRR) begin
          ok = 1'b1;
          cmdNxt = BK_MRR_ACTIVE;
          loadVal = TMR_W'(MRR_C);
        end else if (cmd == CMD_PRE) begin
          ok = 1'b1;
          cmdNxt = allBank ? BK_PRE_ALL : BK_PRECHARGING;
          loadVal = TMR_W'(RP_C);
        end
      end
      BK_READING, BK_WRITING: begin
        expNxt = BK_ACTIVE;
        if (cmd == CMD_READ || cmd == CMD_WRITE) begin
          ok = 1'b1;
          if (autoPre) begin
            cmdNxt = (cmd == CMD_READ) ? BK_READ_AP : BK_WRITE_AP;
            loadVal = TMR_W'(BURST_C + RP_C);
          end else begin
            cmdNxt = (cmd == CMD_READ) ? BK_READING : BK_WRITING;
            loadVal = TMR_W'(BURST_C);
          end
        end else if (cmd == CMD_BST) begin
          ok = 1'b1;
          cmdNxt = BK_ACTIVE;
        end else if (cmd == CMD_PRE && allBank) begin
          ok = 1'b1;
          cmdNxt = BK_PRE_ALL;
          loadVal = TMR_W'(RP_C);
        end
      end
      BK_ACTIVATING, BK_PRECHARGING: begin
        // no command to this bank until the interval is over, except a precharge-all
        expNxt = (state_r == BK_ACTIVATING) ? BK_ACTIVE : BK_IDLE;
        if (cmd == CMD_PRE && allBank) begin
          ok = 1'b1;
          cmdNxt = BK_PRE_ALL;
          loadVal = TMR_W'(RP_C);
        end
      end
      BK_READ_AP, BK_WRITE_AP: expNxt = BK_IDLE;
      BK_PRE_ALL, BK_REF_PB, BK_REF_AB, BK_MR_WRITING, BK_MRR_IDLE: expNxt = BK_IDLE;
      BK_MRR_ACTIVE: expNxt = BK_ACTIVE;
      BK_MRR_RESET: expNxt = BK_RESETTING;
      default: begin
        expNxt = BK_POWER_ON;
        timed = 1'b1;
      end
    endcase
    bad = go && hit && !ok;
    strict = (state_r == BK_PRE_ALL) || (state_r == BK_REF_PB) || (state_r == BK_REF_AB) ||
             (state_r == BK_MR_WRITING) || (state_r == BK_MRR_IDLE) || (state_r == BK_MRR_ACTIVE) ||
             (state_r == BK_MRR_RESET);
    isIdle = (state_r == BK_IDLE);
  end

  // ****************************************************************
  // state and timer
  // ****************************************************************
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= BK_POWER_ON;
    end else if (toPowerOn) begin
      state_r <= BK_POWER_ON;
    end else if (initExit && state_r == BK_RESETTING) begin
      state_r <= BK_IDLE;
    end else if (commit && hit && ok) begin
      state_r <= cmdNxt;
    end else if (timed && tmr_r == TMR_ONE) begin
      state_r <= expNxt;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tmr_r <= '0;
    end else if (commit && hit && ok) begin
      tmr_r <= loadVal;
    end else if (tmr_r != '0) begin
      tmr_r <= tmr_r - TMR_ONE;
    end
  end

endmodule : lbst_bank
`default_nettype wire

// ==== tb/lbst_tracker_props.sv ====
// assertion checker for the bank state tracker ports
`timescale 1ns/1ps
`default_nettype none
module lbst_tracker_props import lbst_pkg::*; #(
  parameter int NUM_BANKS = 8,
  parameter int RCD_C = RCD_CYC,
  parameter int RP_C = RP_CYC,
  parameter int RFCPB_C = RFCPB_CYC,
  parameter int RFCAB_C = RFCAB_CYC,
  parameter int MRW_C = MRW_CYC,
  parameter int BURST_C = BURST_CLKS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // command side
  input wire lbst_cmd_e cmd,
  // status
  input wire logic [NUM_BANKS*BANK_W-1:0] bankState,
  input wire logic illegalCmd_r,
  input wire logic cmdTaken_r,
  input wire logic nopLock_r
);
  // ****************************************************************
  // timed transients seen on banks 0, 1 and 2
  // ****************************************************************
  localparam int AP_C = BURST_C + RP_C;
  wire [BANK_W-1:0] b0 = bankState[0 +: BANK_W];
  wire [BANK_W-1:0] b1 = bankState[BANK_W +: BANK_W];
  wire [BANK_W-1:0] b2 = bankState[2*BANK_W +: BANK_W];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_row_open;
    ##RCD_C (b2 == BK_ACTIVE);
  endsequence
  sequence s_ap_closed;
    ##AP_C (b2 == BK_IDLE);
  endsequence

  a_nop_silent: assert property (cmd == CMD_NOP |=> !illegalCmd_r && !cmdTaken_r)
    else $error("nop produced a pulse");
  a_pulse_excl: assert property (!(illegalCmd_r && cmdTaken_r))
    else $error("taken and illegal together");
  a_lock_refuse: assert property (nopLock_r && cmd != CMD_NOP |=> illegalCmd_r)
    else $error("command accepted during exit lockout");
  a_row_open: assert property ($rose(b2 == BK_ACTIVATING) |-> s_row_open)
    else $error("activating did not end on time");
  a_ap_close: assert property ($rose(b2 == BK_READ_AP) |-> s_ap_closed)
    else $error("auto precharge burst did not close on time");
  a_pre_close: assert property ($rose(b2 == BK_PRECHARGING) |-> ##RP_C (b2 == BK_IDLE))
    else $error("precharge did not end on time");
  a_refpb_end: assert property ($rose(b1 == BK_REF_PB) |-> ##RFCPB_C (b1 == BK_IDLE))
    else $error("bank refresh did not end on time");
  a_refab_end: assert property ($rose(b0 == BK_REF_AB) |-> ##RFCAB_C (b0 == BK_IDLE))
    else $error("all bank refresh did not end on time");
  a_mrw_end: assert property ($rose(b0 == BK_MR_WRITING) |-> ##MRW_C (b0 == BK_IDLE))
    else $error("mode write did not end on time");
endmodule : lbst_tracker_props
`default_nettype wire

// ==== tb/lbst_ctrl_model.sv ====
// controller-side model: drives cke and decoded commands toward the tracker
`timescale 1ns/1ps
`default_nettype none
module lbst_ctrl_model import lbst_pkg::*; (
  // clock and lockout view
  input wire logic ref_clk,
  input wire logic nopLock_r,
  // pins toward the device
  output var logic ckePin,
  output var lbst_cmd_e cmd,
  output var logic [2:0] bankAddr,
  output var logic allBank,
  output var logic autoPre
);
  // ****************************************************************
  // command and cke drivers
  // ****************************************************************
  initial begin
    ckePin = 1'b1;
    cmd = CMD_NOP;
    bankAddr = 3'h0;
    allBank = 1'b0;
    autoPre = 1'b0;
  end

  // one command for one edge, a nop follows so every command is isolated
  task automatic issue(input lbst_cmd_e c, input logic [2:0] b, input logic ab, input logic ap);
    @(posedge ref_clk);
    cmd <= c;
    bankAddr <= b;
    allBank <= ab;
    autoPre <= ap;
    @(posedge ref_clk);
    cmd <= CMD_NOP;
    allBank <= 1'b0;
    autoPre <= 1'b0;
    #1;
  endtask : issue

  // cke passes a synchroniser: the command stands for the edge at which the filtered level change is seen and the edge after,
  // so after a fall it is never seen with cke high on both edges, but after a rise the second edge is
  task automatic cke(input logic v, input lbst_cmd_e c);
    @(posedge ref_clk);
    ckePin <= v;
    repeat (4) @(posedge ref_clk);
    cmd <= c;
    repeat (2) @(posedge ref_clk);
    cmd <= CMD_NOP;
    #1;
  endtask : cke

  // only nops until the exit lockout ends; bounded so a stuck flag cannot hang
  task automatic wait_lock();
    int n;
    n = 0;
    while (nopLock_r === 1'b1 && n < 64) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
  endtask : wait_lock
endmodule : lbst_ctrl_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the bank state tracker
`timescale 1ns/1ps
`default_nettype none
module tb_top import lbst_pkg::*;;
  // ****************************************************************
  // bench timing (longer than the package values except INIT5, which is shortened), clock, reset and instances
  // ****************************************************************
  localparam int RCD = 3, RP = 4, RFPB = 4, RFAB = 5, MRW = 3, MRR = 2;
  localparam int XP = 8, XSR = 14, INIT5 = 20, BURST = 6;
  logic ref_clk;
  logic resetn;
  wire logic ckePin;
  wire lbst_cmd_e cmd;
  wire logic [2:0] bankAddr;
  wire logic allBank;
  wire logic autoPre;
  wire logic [8*BANK_W-1:0] bankState;
  wire lbst_pwr_e powerMode_r;
  wire logic illegalCmd_r;
  wire logic cmdTaken_r;
  wire logic nopLock_r;
  wire logic initDone_r;
  wire logic allIdle_r;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  lbst_ctrl_model ctl (.ref_clk(ref_clk), .nopLock_r(nopLock_r), .ckePin(ckePin), .cmd(cmd),
    .bankAddr(bankAddr), .allBank(allBank), .autoPre(autoPre));
  lbst_tracker #(.NUM_BANKS(8), .RCD_C(RCD), .RP_C(RP), .RFCPB_C(RFPB), .RFCAB_C(RFAB), .MRW_C(MRW),
    .MRR_C(MRR), .XP_C(XP), .XSR_C(XSR), .INIT5_C(INIT5), .BURST_C(BURST)) uut (
    .ref_clk(ref_clk), .resetn(resetn), .ckePin(ckePin), .cmd(cmd), .bankAddr(bankAddr),
    .allBank(allBank), .autoPre(autoPre), .bankState(bankState), .powerMode_r(powerMode_r),
    .illegalCmd_r(illegalCmd_r), .cmdTaken_r(cmdTaken_r), .nopLock_r(nopLock_r),
    .initDone_r(initDone_r), .allIdle_r(allIdle_r));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [BANK_W-1:0] bs(input int i);
    return bankState[i*BANK_W +: BANK_W];
  endfunction : bs

  task automatic chk(input string what, input logic [BANK_W-1:0] exp, input logic [BANK_W-1:0] got);
    n_compared++;
    if (exp !== got) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // a transient must stand exactly n edges, then move on
  task automatic dwell(input int i, input lbst_bank_e s, input int n, input lbst_bank_e nx);
    chk("entered", s, bs(i));
    repeat (n - 1) @(posedge ref_clk);
    #1 chk("held", s, bs(i));
    @(posedge ref_clk);
    #1 chk("left", nx, bs(i));
  endtask : dwell

  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_init();
    chk("power on", BK_POWER_ON, bs(0));
    ctl.issue(CMD_RESET, 3'h0, 1'b0, 1'b0);
    chk("reset", BK_RESETTING, bs(7));
    chk("taken", 1'b1, cmdTaken_r);
    ctl.issue(CMD_MRR, 3'h0, 1'b0, 1'b0);
    dwell(0, BK_MRR_RESET, MRR, BK_RESETTING);
    repeat (INIT5) @(posedge ref_clk);
    #1 chk("init done", 1'b1, initDone_r);
    ctl.cke(1'b0, CMD_NOP);
    chk("pdown", PW_PDOWN, powerMode_r);
    ctl.cke(1'b1, CMD_NOP);
    chk("pd exit", PW_NORMAL, powerMode_r);
    chk("to idle", BK_IDLE, bs(3));
    chk("lock", 1'b1, nopLock_r);
    ctl.issue(CMD_ACT, 3'h2, 1'b0, 1'b0);
    chk("locked act", 1'b1, illegalCmd_r);
    chk("no move", BK_IDLE, bs(2));
    ctl.wait_lock();
  endtask : t_init

  task automatic t_row();
    ctl.issue(CMD_ACT, 3'h2, 1'b0, 1'b0);
    dwell(2, BK_ACTIVATING, RCD, BK_ACTIVE);
    ctl.issue(CMD_READ, 3'h2, 1'b0, 1'b0);
    chk("read", BK_READING, bs(2));
    ctl.issue(CMD_READ, 3'h2, 1'b0, 1'b0);
    dwell(2, BK_READING, BURST, BK_ACTIVE);
    ctl.issue(CMD_WRITE, 3'h2, 1'b0, 1'b0);
    chk("write", BK_WRITING, bs(2));
    ctl.issue(CMD_BST, 3'h5, 1'b0, 1'b0);
    chk("terminate", BK_ACTIVE, bs(2));
    ctl.issue(CMD_READ, 3'h2, 1'b0, 1'b1);
    dwell(2, BK_READ_AP, BURST + RP, BK_IDLE);
  endtask : t_row

  task automatic t_pre();
    ctl.issue(CMD_PRE, 3'h2, 1'b0, 1'b0);
    chk("pre idle bank", BK_PRECHARGING, bs(2));
    ctl.issue(CMD_ACT, 3'h2, 1'b0, 1'b0);
    chk("act in trp", 1'b1, illegalCmd_r);
    repeat (RP) @(posedge ref_clk);
    #1 chk("pre done", BK_IDLE, bs(2));
    ctl.issue(CMD_PRE, 3'h0, 1'b1, 1'b0);
    dwell(3, BK_PRE_ALL, RP, BK_IDLE);
  endtask : t_pre

  task automatic t_ref();
    ctl.issue(CMD_REF, 3'h1, 1'b0, 1'b0);
    dwell(1, BK_REF_PB, RFPB, BK_IDLE);
    ctl.issue(CMD_REF, 3'h0, 1'b1, 1'b0);
    chk("ref all", BK_REF_AB, bs(5));
    ctl.issue(CMD_ACT, 3'h4, 1'b0, 1'b0);
    chk("act in ref", 1'b1, illegalCmd_r);
    repeat (RFAB) @(posedge ref_clk);
    #1 chk("ref end", BK_IDLE, bs(4));
    chk("all idle", 1'b1, allIdle_r);
    ctl.issue(CMD_MRW, 3'h0, 1'b0, 1'b0);
    dwell(0, BK_MR_WRITING, MRW, BK_IDLE);
  endtask : t_ref

  task automatic t_sref();
    ctl.cke(1'b0, CMD_SREF);
    chk("sref", PW_SREF, powerMode_r);
    ctl.cke(1'b1, CMD_NOP);
    repeat (XP) @(posedge ref_clk);
    #1 chk("xsr lock", 1'b1, nopLock_r);
    ctl.wait_lock();
    chk("sref idle", BK_IDLE, bs(6));
  endtask : t_sref

  // ****************************************************************
  // main sequence and hang guard
  // ****************************************************************
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  initial begin
    resetn = 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (10) @(posedge ref_clk);
    t_init();
    t_row();
    t_pre();
    t_ref();
    t_sref();
    conclude();
  end
endmodule : tb_top

bind lbst_tracker lbst_tracker_props #(.NUM_BANKS(NUM_BANKS), .RCD_C(RCD_C), .RP_C(RP_C),
  .RFCPB_C(RFCPB_C), .RFCAB_C(RFCAB_C), .MRW_C(MRW_C), .BURST_C(BURST_C)) u_props (
  .ref_clk(ref_clk), .resetn(resetn), .cmd(cmd), .bankState(bankState),
  .illegalCmd_r(illegalCmd_r), .cmdTaken_r(cmdTaken_r), .nopLock_r(nopLock_r));
`default_nettype wire
